/* File: ljp_pkg.sv */
/*
  Shared constants and types for the latch-corrected speed-point sequencer.
  Assumes one 200 MHz clock and a word-wide register port of 8 address bits.
*/
package ljp_pkg;
  localparam int AW = 8;
  localparam int DW = 32;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_SPEED     = 8'h08;
  localparam logic [7:0] REG_LATCH_POS = 8'h0c;
  localparam logic [7:0] REG_ERR_CODE  = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START   = 0;
  localparam int CTRL_LREQ    = 1;
  localparam int CTRL_ERR_CLR = 2;

  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_WAIT = 2;
  localparam int STAT_ERR  = 3;
  localparam int STAT_W    = 4;

  localparam int IRQ_DONE  = 0;
  localparam int IRQ_LATCH = 1;
  localparam int IRQ_ERR   = 2;
  localparam int IRQ_W     = 3;

  localparam logic [15:0] ERR_NONE        = 16'h0000;
  localparam logic [15:0] ERR_MULTI_LATCH = 16'h3070;
  localparam logic [31:0] RST_WORD        = 32'h0000_0000;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int LATCH_START_MS = 1;
  // longest time: rounds down
  localparam int LATCH_START_CYC = (LATCH_START_MS * 1000000000) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SPEED = 2'b01,
    ST_END   = 2'b10,
    ST_ESTOP = 2'b11
  } ljp_state_t;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } ljp_bus_t;

  typedef struct packed {
    logic          valid;
    logic [DW-1:0] speed;
    logic [DW-1:0] torque;
  } ljp_mon_t;
endpackage

/* File: ljp_pin_sync.sv */
/*
  Three-stage synchroniser for one pin level with agreement filter.
  Assumes the pin is asynchronous to sys_clk_in.
*/
`timescale 1ns/1ps
module ljp_pin_sync (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      lvl_out
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;

  always_comb begin
    sh_d  = {sh_q[1:0], pin_in};
    // stage 0 feeds only stage 1; change accepted once 1 and 2 agree
    lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sh_q  <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      sh_q  <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign lvl_out = lvl_q;
endmodule

/* File: ljp_seq.sv */
/*
  One-axis speed-point sequencer with latch-triggered hand-over to the
  following end-point table, latch position capture and register port.
  Assumes latch reports and monitor words arrive on sys_clk_in, and the
  motion core pulses end_done_in when the end-point table finishes.
*/
`timescale 1ns/1ps
module ljp_seq #(
  parameter int LATCH_START_MAX_CYC = ljp_pkg::LATCH_START_CYC
) (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_in,
  input  wire ljp_pkg::ljp_bus_t      bus_in,
  output logic [ljp_pkg::DW-1:0]      rd_data_out,
  input  wire logic                   start_pin_in,
  input  wire logic                   latch_event_in,
  input  wire logic [ljp_pkg::DW-1:0] latch_pos_in,
  input  wire logic                   end_done_in,
  input  wire ljp_pkg::ljp_mon_t      mon_in,
  output ljp_pkg::ljp_mon_t           mon_out,
  output logic [ljp_pkg::DW-1:0]      speed_cmd_out,
  output logic                        end_start_out,
  output logic                        err_stop_out,
  output logic                        irq_out
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ljp_pkg::ljp_state_t           state_q, state_d;
  logic                          lreq_q, lreq_d;
  logic                          wait_q, wait_d;
  logic                          busy_q, busy_d;
  logic                          done_q, done_d;
  logic                          used_q, used_d;
  logic [ljp_pkg::DW-1:0]        speed_q, speed_d;
  logic [ljp_pkg::DW-1:0]        lpos_q, lpos_d;
  logic [15:0]                   err_q, err_d;
  logic [ljp_pkg::IRQ_W-1:0]     ist_q, ist_d;
  logic [ljp_pkg::IRQ_W-1:0]     imask_q, imask_d;
  logic [ljp_pkg::IRQ_W-1:0]     iset;
  logic [ljp_pkg::DW-1:0]        rd_q, rd_d;
  logic [ljp_pkg::DW-1:0]        cmd_q, cmd_d;
  logic                          est_q, est_d;
  logic                          stop_q, stop_d;
  logic                          irq_q, irq_d;
  ljp_pkg::ljp_mon_t             mon_q, mon_d;
  logic                          pin_lvl, pin_q;
  logic                          pin_rise, latch_ev, trig, start_cmd, wr_ctrl;
  logic [ljp_pkg::STAT_W-1:0]    status;

  ljp_pin_sync u_pin_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .pin_in     (start_pin_in),
    .lvl_out    (pin_lvl)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    wr_ctrl   = bus_in.wr && (bus_in.addr == ljp_pkg::REG_CTRL);
    start_cmd = wr_ctrl && bus_in.wdata[ljp_pkg::CTRL_START];
    pin_rise  = pin_lvl && !pin_q;
    latch_ev  = latch_event_in && wait_q;
    // latch mode replaces the pin as trigger
    trig      = wait_q ? latch_ev : pin_rise;
    lreq_d    = wr_ctrl ? bus_in.wdata[ljp_pkg::CTRL_LREQ] : lreq_q;
    wait_d    = lreq_q && (state_q != ljp_pkg::ST_ESTOP);
    state_d   = state_q;
    busy_d    = busy_q;
    done_d    = done_q;
    used_d    = used_q;
    lpos_d    = lpos_q;
    err_d     = err_q;
    cmd_d     = '0;
    est_d     = 1'b0;
    stop_d    = 1'b0;
    iset      = '0;
    case (state_q)
      ljp_pkg::ST_IDLE: begin
        if (start_cmd) begin
          state_d = ljp_pkg::ST_SPEED;
          busy_d  = 1'b1;
          done_d  = 1'b0;
          used_d  = 1'b0;
        end
      end
      ljp_pkg::ST_SPEED: begin
        cmd_d = speed_q;
        if (trig) begin
          state_d = ljp_pkg::ST_END;
          est_d   = 1'b1;
          cmd_d   = '0;
          if (wait_q) begin
            lpos_d                   = latch_pos_in;
            used_d                   = 1'b1;
            iset[ljp_pkg::IRQ_LATCH] = 1'b1;
          end
        end
      end
      ljp_pkg::ST_END: begin
        if (latch_ev && used_q) begin
          state_d                = ljp_pkg::ST_ESTOP;
          err_d                  = ljp_pkg::ERR_MULTI_LATCH;
          busy_d                 = 1'b0;
          stop_d                 = 1'b1;
          iset[ljp_pkg::IRQ_ERR] = 1'b1;
        end else if (end_done_in) begin
          state_d                 = ljp_pkg::ST_IDLE;
          busy_d                  = 1'b0;
          done_d                  = 1'b1;
          iset[ljp_pkg::IRQ_DONE] = 1'b1;
        end
      end
      ljp_pkg::ST_ESTOP: begin
        // held until software acknowledges; a fresh start is refused here
        stop_d = 1'b1;
        if (wr_ctrl && bus_in.wdata[ljp_pkg::CTRL_ERR_CLR]) begin
          state_d = ljp_pkg::ST_IDLE;
          err_d   = ljp_pkg::ERR_NONE;
          stop_d  = 1'b0;
        end
      end
      default: state_d = ljp_pkg::ST_IDLE;
    endcase
    // monitor words withheld while latch speed-point phase runs
    mon_d = mon_in;
    if ((state_q == ljp_pkg::ST_SPEED) && wait_q) begin
      mon_d = '0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ljp_pkg::ST_IDLE;
      lreq_q  <= 1'b0;
      wait_q  <= 1'b0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      used_q  <= 1'b0;
      lpos_q  <= ljp_pkg::RST_WORD;
      err_q   <= ljp_pkg::ERR_NONE;
      cmd_q   <= ljp_pkg::RST_WORD;
      est_q   <= 1'b0;
      stop_q  <= 1'b0;
      mon_q   <= '0;
      pin_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      lreq_q  <= lreq_d;
      wait_q  <= wait_d;
      busy_q  <= busy_d;
      done_q  <= done_d;
      used_q  <= used_d;
      lpos_q  <= lpos_d;
      err_q   <= err_d;
      cmd_q   <= cmd_d;
      est_q   <= est_d;
      stop_q  <= stop_d;
      mon_q   <= mon_d;
      pin_q   <= pin_lvl;
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    status                     = '0;
    status[ljp_pkg::STAT_BUSY] = busy_q;
    status[ljp_pkg::STAT_DONE] = done_q;
    status[ljp_pkg::STAT_WAIT] = wait_q;
    status[ljp_pkg::STAT_ERR]  = (state_q == ljp_pkg::ST_ESTOP);
    speed_d = speed_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    if (bus_in.wr && (bus_in.addr == ljp_pkg::REG_SPEED)) begin
      speed_d = bus_in.wdata;
    end
    if (bus_in.wr && (bus_in.addr == ljp_pkg::REG_IRQ_MASK)) begin
      imask_d = bus_in.wdata[ljp_pkg::IRQ_W-1:0];
    end
    if (bus_in.wr && (bus_in.addr == ljp_pkg::REG_IRQ_STAT)) begin
      ist_d = ist_q & ~bus_in.wdata[ljp_pkg::IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    ist_d = ist_d | iset;
    irq_d = |(ist_d & imask_d);
    rd_d  = '0;
    if (bus_in.rd) begin
      if (bus_in.addr == ljp_pkg::REG_CTRL) begin
        rd_d[ljp_pkg::CTRL_LREQ] = lreq_q;
      end else if (bus_in.addr == ljp_pkg::REG_STATUS) begin
        rd_d[ljp_pkg::STAT_W-1:0] = status;
      end else if (bus_in.addr == ljp_pkg::REG_SPEED) begin
        rd_d = speed_q;
      end else if (bus_in.addr == ljp_pkg::REG_LATCH_POS) begin
        rd_d = lpos_q;
      end else if (bus_in.addr == ljp_pkg::REG_ERR_CODE) begin
        rd_d[15:0] = err_q;
      end else if (bus_in.addr == ljp_pkg::REG_IRQ_STAT) begin
        rd_d[ljp_pkg::IRQ_W-1:0] = ist_q;
      end else if (bus_in.addr == ljp_pkg::REG_IRQ_MASK) begin
        rd_d[ljp_pkg::IRQ_W-1:0] = imask_q;
      end else begin
        rd_d = '0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      speed_q <= ljp_pkg::RST_WORD;
      imask_q <= '0;
      ist_q   <= '0;
      irq_q   <= 1'b0;
      rd_q    <= ljp_pkg::RST_WORD;
    end else begin
      speed_q <= speed_d;
      imask_q <= imask_d;
      ist_q   <= ist_d;
      irq_q   <= irq_d;
      rd_q    <= rd_d;
    end
  end

  assign rd_data_out   = rd_q;
  assign mon_out       = mon_q;
  assign speed_cmd_out = cmd_q;
  assign end_start_out = est_q;
  assign err_stop_out  = stop_q;
  assign irq_out       = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [31:0] lat_cnt_q;
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lat_cnt_q <= '0;
    end else if (latch_ev && (state_q == ljp_pkg::ST_SPEED)) begin
      lat_cnt_q <= 32'h0000_0001;
    end else if (est_q) begin
      lat_cnt_q <= '0;
    end else if (lat_cnt_q != '0) begin
      lat_cnt_q <= lat_cnt_q + 32'h0000_0001;
    end
  end

  a_speed_phase_cmd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && !trig |=> (speed_cmd_out == $past(speed_q)))
    else $error("speed command not at target");
  a_wait_entry: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lreq_q && (state_q != ljp_pkg::ST_ESTOP) |=> wait_q)
    else $error("latch wait not entered");
  a_latch_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && latch_ev |=> end_start_out && (state_q == ljp_pkg::ST_END))
    else $error("latch did not start end table");
  a_pin_ignored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && wait_q && !latch_event_in |=> !end_start_out)
    else $error("start pin acted in latch mode");
  a_pos_capture: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && latch_ev |=> (lpos_q == $past(latch_pos_in)))
    else $error("latched position not captured");
  // counter only spans latch to start pulse; the bench shrinks the bound
  a_start_delay: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    lat_cnt_q < LATCH_START_MAX_CYC)
    else $error("end table start too late");

  sequence s_err_stop_held;
    err_stop_out && !busy_q && (err_q == ljp_pkg::ERR_MULTI_LATCH) ##1 err_stop_out;
  endsequence

  a_second_latch: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_END) && latch_ev && used_q
      |=> s_err_stop_held)
    else $error("second latch did not stop axis");
  a_trig_start: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && !wait_q && pin_rise |=> end_start_out && (speed_cmd_out == '0))
    else $error("pin edge did not start end table");
  a_latch_ignored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && !wait_q && latch_event_in && !pin_rise |=> !end_start_out)
    else $error("latch acted without request");
  a_mon_blank: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    (state_q == ljp_pkg::ST_SPEED) && wait_q |=> !mon_out.valid && (mon_out.speed == '0))
    else $error("monitor shown in latch phase");
  a_req_drop: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !lreq_q |=> !wait_q)
    else $error("wait kept after request dropped");
endmodule

/* File: ljp_amp_model.sv */
/*
  Servo amplifier stand-in: latch reports and monitor words.
  Assumes the sequencer's clock; the bench calls fire() for one latch.
*/
`timescale 1ns/1ps
module ljp_amp_model (
  input  wire logic         sys_clk_in,
  output logic              latch_event_out,
  output logic [31:0]       latch_pos_out,
  output ljp_pkg::ljp_mon_t mon_out
);
  initial begin
    latch_event_out = 1'b0;
    latch_pos_out   = 32'h0;
  end

  // fresh words every cycle so a stale copy cannot pass
  always @(posedge sys_clk_in) begin
    mon_out <= {1'b1, $urandom(), $urandom()};
  end

  // position only meaningful beside the report; inverted after it
  task automatic fire(input logic [31:0] pos);
    @(posedge sys_clk_in);
    latch_event_out <= 1'b1;
    latch_pos_out   <= pos;
    @(posedge sys_clk_in);
    latch_event_out <= 1'b0;
    latch_pos_out   <= ~pos;
  endtask
endmodule

/* File: latch_corrected_jog_positioning_tb_top.sv */
/*
  Self-checking bench for the speed-point sequencer with latch hand-over.
  Assumes ljp_seq and ljp_amp_model; short bound on the start check.
*/
`timescale 1ns/1ps
module latch_corrected_jog_positioning_tb_top;
  logic              sys_clk_in;
  logic              rst_in;
  ljp_pkg::ljp_bus_t bus;
  logic [31:0]       rd_data;
  logic              start_pin;
  logic              latch_ev;
  logic [31:0]       latch_pos;
  logic              end_done;
  ljp_pkg::ljp_mon_t mon_in;
  ljp_pkg::ljp_mon_t mon_o;
  ljp_pkg::ljp_mon_t mv;
  logic [31:0]       speed_cmd;
  logic              end_start;
  logic              err_stop;
  logic              irq;
  int                error_cnt = 0;
  int                checked = 0;
  logic [31:0]       exp_speed;
  logic [31:0]       pos_q[$];
  logic [31:0]       v;
  bit                seen;
  logic [7:0]        addrs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};

  ljp_seq #(.LATCH_START_MAX_CYC(8)) dut_u (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus), .rd_data_out(rd_data),
    .start_pin_in(start_pin), .latch_event_in(latch_ev), .latch_pos_in(latch_pos),
    .end_done_in(end_done), .mon_in(mon_in), .mon_out(mon_o), .speed_cmd_out(speed_cmd),
    .end_start_out(end_start), .err_stop_out(err_stop), .irq_out(irq)
  );

  ljp_amp_model amp_u (
    .sys_clk_in(sys_clk_in), .latch_event_out(latch_ev), .latch_pos_out(latch_pos),
    .mon_out(mon_in)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checked++;
    if (seen_v !== exp_v) begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen_v, exp_v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_in);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge sys_clk_in);
    bus.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic wait_es(input int n, output bit s);
    s = 0;
    repeat (n) begin
      @(posedge sys_clk_in);
      #1 if (end_start === 1'b1) s = 1;
    end
  endtask

  task automatic pin(input logic lvl);
    @(posedge sys_clk_in);
    start_pin <= lvl;
  endtask

  task automatic finish_op();
    @(posedge sys_clk_in);
    end_done <= 1'b1;
    @(posedge sys_clk_in);
    end_done <= 1'b0;
  endtask

  task automatic wrap_up();
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // whole run is under 150 cycles; this is far beyond it
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h74008aaf));
    rst_in    = 1'b1;
    bus       = '0;
    start_pin = 1'b0;
    end_done  = 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    foreach (addrs[i]) begin
      rd(addrs[i], v);
      chk(v, 32'h0);
    end
    exp_speed = $urandom_range(32'h7fff_ffff, 1);
    wr(ljp_pkg::REG_SPEED, exp_speed);
    rd(ljp_pkg::REG_SPEED, v);
    chk(v, exp_speed);
    // plain run: pin hands over to the end-point table
    wr(ljp_pkg::REG_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(speed_cmd, exp_speed);
    chk(mon_o.valid, 1'b1);
    mv = mon_in;
    @(posedge sys_clk_in);
    #1 chk(mon_o.speed, mv.speed);
    chk(mon_o.torque, mv.torque);
    pin(1'b1);
    wait_es(8, seen);
    chk(seen, 1'b1);
    pin(1'b0);
    finish_op();
    rd(ljp_pkg::REG_STATUS, v);
    chk(v, 32'h2);
    rd(ljp_pkg::REG_IRQ_STAT, v);
    chk(v, 32'h1);
    chk(irq, 1'b0);
    wr(ljp_pkg::REG_IRQ_MASK, 32'h7);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(irq, 1'b1);
    wr(ljp_pkg::REG_IRQ_STAT, 32'h1);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(irq, 1'b0);
    // latch run, then a second latch in the same operation
    wr(ljp_pkg::REG_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk_in);
    rd(ljp_pkg::REG_STATUS, v);
    chk(v[2], 1'b1);
    // one independent axis only; no distance register to program here
    wr(ljp_pkg::REG_CTRL, 32'h3);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(mon_o.speed | mon_o.torque, 32'h0);
    chk(mon_o.valid, 1'b0);
    rd(ljp_pkg::REG_STATUS, v);
    chk(v[2:0], 3'b101);
    pin(1'b1);
    wait_es(8, seen);
    chk(seen, 1'b0);
    pin(1'b0);
    pos_q.push_back($urandom());
    amp_u.fire(pos_q[0]);
    #1 chk(end_start, 1'b1);
    chk(speed_cmd, 32'h0);
    rd(ljp_pkg::REG_LATCH_POS, v);
    chk(v, pos_q.pop_front());
    rd(ljp_pkg::REG_IRQ_STAT, v);
    chk(v, 32'h2);
    chk(irq, 1'b1);
    wr(ljp_pkg::REG_IRQ_STAT, 32'h2);
    amp_u.fire($urandom());
    repeat (2) @(posedge sys_clk_in);
    #1 chk(err_stop, 1'b1);
    chk(irq, 1'b1);
    rd(ljp_pkg::REG_ERR_CODE, v);
    chk(v, 32'h3070);
    rd(ljp_pkg::REG_STATUS, v);
    chk(v[3:0], 4'h8);
    wr(ljp_pkg::REG_CTRL, 32'h4);
    repeat (2) @(posedge sys_clk_in);
    #1 chk(err_stop, 1'b0);
    wr(ljp_pkg::REG_IRQ_STAT, 32'h7);
    // request dropped mid-run: latch ignored, pin back in charge
    wr(ljp_pkg::REG_CTRL, 32'h2);
    repeat (2) @(posedge sys_clk_in);
    wr(ljp_pkg::REG_CTRL, 32'h3);
    wr(ljp_pkg::REG_CTRL, 32'h0);
    repeat (3) @(posedge sys_clk_in);
    rd(ljp_pkg::REG_STATUS, v);
    chk(v[2], 1'b0);
    amp_u.fire($urandom());
    #1 chk(end_start, 1'b0);
    wait_es(4, seen);
    chk(seen, 1'b0);
    pin(1'b1);
    wait_es(8, seen);
    chk(seen, 1'b1);
    pin(1'b0);
    finish_op();
    rd(ljp_pkg::REG_STATUS, v);
    chk(v[1:0], 2'b10);
    wrap_up();
  end
endmodule
